// ===== rtl/tssp_defs.svh
// constants for the temperature sensor serial port
// assumes a 100 MHz system clock and a host-driven shift clock
`ifndef TSSP_DEFS_SVH
`define TSSP_DEFS_SVH

// serial frame layout
`define TSSP_CNT_W 5
`define TSSP_PHASE_BITS 5'h10
`define TSSP_LAST_BIT 5'h1f
`define TSSP_DRIVE_BITS 5'h0e
`define TSSP_WORD_MSB 5'h0f
`define TSSP_WORD_W 16
`define TSSP_CMD_W 8
`define TSSP_RX_CNT_W 4
`define TSSP_RX_MIN 4'h8
`define TSSP_CMD_SHUTDOWN 8'hff

// temperature word fields
`define TSSP_TEMP_W 11
`define TSSP_FILL_ONES 3'h7
`define TSSP_FILL_UNDRIVEN 2'h0

// conversion timing
`define TSSP_CLK_MHZ 100
`define TSSP_CONV_TIME_MS 140
`define TSSP_CONV_CNT_W 32

`endif

// ===== rtl/tssp_pkg.sv
// types shared by the temperature sensor serial port files
// assumes tssp_defs.svh for numeric constants
package tssp_pkg;

  // operating mode held by the device
  typedef enum logic {
    TSSP_MODE_CONVERT,
    TSSP_MODE_SHUTDOWN
  } tssp_mode_t;

  // conversion engine state
  typedef enum logic {
    TSSP_CONV_IDLE,
    TSSP_CONV_BUSY
  } tssp_conv_t;

endpackage

// ===== rtl/tssp_sync.sv
// two flip-flop level synchroniser into the system clock domain
// assumes the input is a level or a toggle from another domain
`timescale 1ns/1ps
`default_nettype none

module tssp_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;

  // first stage feeds only the second
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/tssp_conv.sv
// conversion engine timer: captures the converter code after a fixed time
// assumes temp_code_in is settled in the system clock domain
`timescale 1ns/1ps
`default_nettype none
`include "tssp_defs.svh"

module tssp_conv #(
  parameter int unsigned CONV_CYCLES = `TSSP_CONV_TIME_MS * 1000 * `TSSP_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // control
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [`TSSP_TEMP_W-1:0] temp_code_in,
  // results
  output logic [`TSSP_TEMP_W-1:0] result_out,
  output logic valid_out,
  output logic busy_out
);

  tssp_pkg::tssp_conv_t state;
  logic [`TSSP_CONV_CNT_W-1:0] count;
  logic finish;

  assign finish = (state == tssp_pkg::TSSP_CONV_BUSY) &&
                  (count == `TSSP_CONV_CNT_W'(CONV_CYCLES - 1));
  assign busy_out = (state == tssp_pkg::TSSP_CONV_BUSY);

  // state: a running conversion is never aborted, idle restarts on request
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= tssp_pkg::TSSP_CONV_IDLE;
    end else begin
      unique case (state)
        tssp_pkg::TSSP_CONV_IDLE: begin
          if (run_in || restart_in) begin
            state <= tssp_pkg::TSSP_CONV_BUSY;
          end
        end
        tssp_pkg::TSSP_CONV_BUSY: begin
          if (finish) begin
            state <= tssp_pkg::TSSP_CONV_IDLE;
          end
        end
      endcase
    end
  end

  // conversion time counter
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (state == tssp_pkg::TSSP_CONV_BUSY && !finish) begin
      count <= count + `TSSP_CONV_CNT_W'(1);
    end else begin
      count <= '0;
    end
  end

  // result and first-conversion flag
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_out <= '0;
      valid_out <= 1'b0;
    end else if (finish) begin
      result_out <= temp_code_in;
      valid_out <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/tssp_top.sv
// temperature sensor serial port, device side, with conversion engine
// assumes the host drives cs_n_in and shift_clock_in; sio is split in three
//
// Behaviour
// - after power-up the device runs continuous conversion, not shutdown
// - output word is invalid until the first conversion after power-up ends
// - power-up reset returns mode and all registers except the link counters, command shifter and wrap flag, which clear on chip select high, to defaults
// - output changes on falling shift clock, input sampled on rising
// - full exchange is 32 clocks: 16 transmit then 16 receive
// - data line is high impedance while chip select is high
// - first bit driven at chip select fall, later bits on falling edges
// - after 14 bits the data line is released for the rest of transmit
// - host may end the transfer at any time during transmit
// - output word reloads only while chip select is high
// - receive starts after 16 clocks and lasts up to 16 more
// - receive bits shift into an 8-bit command register on rising edges
// - only the last eight bits received before chip select rises count; here the end of a full 32-clock exchange also takes them
// - all ones selects shutdown, any zero selects conversion
// - other codes are reserved; treated here as conversion
// - in shutdown the identification word is transmitted instead
// - reads never abort a conversion and return the latest result
// - a completed read refreshes the word and restarts conversion
// - serial port keeps working in shutdown
// - word is 11-bit temperature, three ones, two undriven bits
`timescale 1ns/1ps
`default_nettype none
`include "tssp_defs.svh"

module tssp_top #(
  parameter int unsigned CONV_CYCLES = `TSSP_CONV_TIME_MS * 1000 * `TSSP_CLK_MHZ,
  parameter logic [`TSSP_WORD_W-1:0] DEVICE_ID = 16'h5a14 // arbitrary value
) (
  // system clock and power-up reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // serial link from the host
  input wire logic shift_clock_in,
  input wire logic cs_n_in,
  input wire logic sio_in,
  output logic sio_out,
  output logic sio_oe_out,
  // converter code
  input wire logic [`TSSP_TEMP_W-1:0] temp_code_in,
  // status
  output logic shutdown_out,
  output logic temp_valid_out,
  output logic conv_busy_out
);

  // picks one bit of a word, msb first by frame position
  function automatic logic word_bit(input logic [`TSSP_WORD_W-1:0] word,
                                    input logic [`TSSP_CNT_W-1:0] pos);
    logic [`TSSP_CNT_W-1:0] idx;
    idx = `TSSP_WORD_MSB - pos;
    word_bit = word[idx[3:0]];
  endfunction

  // decodes a received command: all ones means shutdown
  function automatic logic is_shutdown(input logic [`TSSP_CMD_W-1:0] cmd);
    is_shutdown = (cmd == `TSSP_CMD_SHUTDOWN);
  endfunction

  // ---------------- link domain (shift clock) ----------------

  logic [`TSSP_CNT_W-1:0] bit_cnt;
  logic [`TSSP_CNT_W-1:0] out_pos;
  logic [`TSSP_CMD_W-1:0] cmd_shift;
  logic [`TSSP_RX_CNT_W-1:0] rx_cnt;
  logic in_receive;
  logic frame_end;
  logic wrap_seen;
  logic [`TSSP_CMD_W-1:0] wrap_cmd;
  logic wrap_tgl;
  logic [`TSSP_CMD_W-1:0] cs_cmd;
  logic cs_tgl;

  // ---------------- system domain ----------------

  logic cs_high;
  logic cs_tgl_sync;
  logic wrap_tgl_sync;
  logic cs_tgl_seen;
  logic wrap_tgl_seen;
  logic cs_high_d;
  logic read_done;
  tssp_pkg::tssp_mode_t mode;
  logic [`TSSP_WORD_W-1:0] temp_word;
  logic [`TSSP_TEMP_W-1:0] conv_result;
  logic conv_valid;
  logic conv_busy;

  assign in_receive = (bit_cnt >= `TSSP_PHASE_BITS);
  assign frame_end = (bit_cnt == `TSSP_LAST_BIT);

  // rising-edge bit counter, wraps every 32 clocks for chained frames
  always_ff @(posedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= bit_cnt + `TSSP_CNT_W'(1);
    end
  end

  // output position advances on falling edges only
  always_ff @(negedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_pos <= '0;
    end else begin
      out_pos <= bit_cnt;
    end
  end

  // command shift register fills during the receive phase
  always_ff @(posedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cmd_shift <= '0;
    end else if (frame_end) begin
      cmd_shift <= '0;
    end else if (in_receive) begin
      cmd_shift <= {cmd_shift[`TSSP_CMD_W-2:0], sio_in};
    end
  end

  // count of received bits, saturating at eight
  always_ff @(posedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rx_cnt <= '0;
    end else if (frame_end) begin
      rx_cnt <= '0;
    end else if (in_receive && rx_cnt != `TSSP_RX_MIN) begin
      rx_cnt <= rx_cnt + `TSSP_RX_CNT_W'(1);
    end
  end

  // marks that a full 32-clock exchange ended inside this frame
  always_ff @(posedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      wrap_seen <= 1'b0;
    end else if (frame_end) begin
      wrap_seen <= 1'b1;
    end
  end

  // command taken at the end of a full exchange with chip select still low
  always_ff @(posedge shift_clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wrap_cmd <= '0;
      wrap_tgl <= 1'b0;
    end else if (frame_end) begin
      wrap_cmd <= {cmd_shift[`TSSP_CMD_W-2:0], sio_in};
      wrap_tgl <= ~wrap_tgl;
    end
  end

  // command taken at chip select rise; old values are sampled before the
  // same edge clears the link counters
  always_ff @(posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_cmd <= '0;
      cs_tgl <= 1'b0;
    end else if (rx_cnt == `TSSP_RX_MIN) begin
      cs_cmd <= cmd_shift;
      cs_tgl <= ~cs_tgl;
    end
  end

  // transmit mux: temp or id chosen by the mode in force for this exchange;
  // temp_word only changes while chip select is high; mode also changes at the end of a full exchange
  logic tx_shut;
  logic [`TSSP_WORD_W-1:0] tx_word;
  assign tx_shut = wrap_seen ? is_shutdown(wrap_cmd) : (mode == tssp_pkg::TSSP_MODE_SHUTDOWN);
  assign tx_word = tx_shut ? DEVICE_ID : temp_word;
  assign sio_out = word_bit(tx_word, out_pos);
  assign sio_oe_out = !cs_n_in && (out_pos < `TSSP_DRIVE_BITS);

  // ---------------- crossings into the system domain ----------------

  tssp_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(cs_n_in),
    .sync_out(cs_high)
  );

  tssp_sync #(.RESET_VAL(1'b0)) u_sync_cs_tgl (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(cs_tgl),
    .sync_out(cs_tgl_sync)
  );

  tssp_sync #(.RESET_VAL(1'b0)) u_sync_wrap_tgl (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(wrap_tgl),
    .sync_out(wrap_tgl_sync)
  );

  // toggle history for event detection
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_tgl_seen <= 1'b0;
      wrap_tgl_seen <= 1'b0;
      cs_high_d <= 1'b1;
    end else begin
      cs_tgl_seen <= cs_tgl_sync;
      wrap_tgl_seen <= wrap_tgl_sync;
      cs_high_d <= cs_high;
    end
  end

  // a read completes when chip select is seen rising
  assign read_done = cs_high && !cs_high_d;

  // mode register: conversion at power-up, updated by received commands
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= tssp_pkg::TSSP_MODE_CONVERT;
    end else if (cs_tgl_sync != cs_tgl_seen) begin
      mode <= is_shutdown(cs_cmd) ? tssp_pkg::TSSP_MODE_SHUTDOWN
                                  : tssp_pkg::TSSP_MODE_CONVERT;
    end else if (wrap_tgl_sync != wrap_tgl_seen) begin
      mode <= is_shutdown(wrap_cmd) ? tssp_pkg::TSSP_MODE_SHUTDOWN
                                    : tssp_pkg::TSSP_MODE_CONVERT;
    end
  end

  // conversion engine, started only in conversion mode
  tssp_conv #(.CONV_CYCLES(CONV_CYCLES)) u_conv (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .run_in(mode == tssp_pkg::TSSP_MODE_CONVERT),
    .restart_in(read_done && mode == tssp_pkg::TSSP_MODE_CONVERT),
    .temp_code_in(temp_code_in),
    .result_out(conv_result),
    .valid_out(conv_valid),
    .busy_out(conv_busy)
  );

  // output word reloads from the latest result only between frames
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_word <= '0;
    end else if (cs_high && cs_high_d) begin
      temp_word <= {conv_result, `TSSP_FILL_ONES, `TSSP_FILL_UNDRIVEN};
    end
  end

  // status outputs
  assign shutdown_out = (mode == tssp_pkg::TSSP_MODE_SHUTDOWN);
  assign temp_valid_out = conv_valid;
  assign conv_busy_out = conv_busy;

endmodule

`default_nettype wire

// ===== testbench/tssp_top_properties.sv
// checker for the serial port top, sees only its ports
// assumes binding to tssp_top; mclk_in domain plus a shift clock count
`timescale 1ns/1ps
`default_nettype none
module tssp_top_chk (
  // clocks and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // serial link
  input wire logic shift_clock_in,
  input wire logic cs_n_in,
  input wire logic sio_oe_out,
  // status
  input wire logic shutdown_out,
  input wire logic temp_valid_out,
  input wire logic conv_busy_out
);
  logic [4:0] falls;
  // falling shift clock edges since chip select fell
  always_ff @(negedge shift_clock_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      falls <= 5'h00;
    end else begin
      falls <= falls + 5'h01;
    end
  end
  property p_idle_hiz;
    @(posedge mclk_in) disable iff (!rst_n_in) cs_n_in |-> !sio_oe_out;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("line driven while deselected");
  property p_start_drive;
    @(posedge mclk_in) disable iff (!rst_n_in) $fell(cs_n_in) |-> sio_oe_out;
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("first bit not driven");
  property p_rx_release;
    @(negedge shift_clock_in) disable iff (cs_n_in || !rst_n_in)
      (falls >= 5'h0e && falls <= 5'h1e) |-> !sio_oe_out;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("line held past fourteen bits");
  property p_reset_mode;
    @(posedge mclk_in) disable iff (!rst_n_in) !$past(rst_n_in) |-> !shutdown_out ##1 !shutdown_out;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("not converting after reset");
  property p_reset_invalid;
    @(posedge mclk_in) disable iff (!rst_n_in) !$past(rst_n_in) |-> !temp_valid_out;
  endproperty
  a_reset_invalid: assert property (p_reset_invalid) else $error("valid too early");
  property p_valid_cause;
    @(posedge mclk_in) disable iff (!rst_n_in) $rose(temp_valid_out) |-> $past(conv_busy_out);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid without a conversion");
  property p_busy_start;
    @(posedge mclk_in) disable iff (!rst_n_in) !$past(rst_n_in) |=> conv_busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("no conversion after reset");
  property p_conv_runs;
    @(posedge mclk_in) disable iff (!rst_n_in) (!conv_busy_out && !shutdown_out) |-> ##[0:4] conv_busy_out;
  endproperty
  a_conv_runs: assert property (p_conv_runs) else $error("conversion not restarted");
  property p_mode_hold;
    @(posedge mclk_in) disable iff (!rst_n_in) cs_n_in [*8] |=> $stable(shutdown_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed while idle");
endmodule
bind tssp_top tssp_top_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .shift_clock_in(shift_clock_in),
  .cs_n_in(cs_n_in), .sio_oe_out(sio_oe_out), .shutdown_out(shutdown_out),
  .temp_valid_out(temp_valid_out), .conv_busy_out(conv_busy_out));
`default_nettype wire

// ===== testbench/tssp_host.sv
// host model: chip select, shift clock and its half of the data line
// assumes an 80 ns shift clock that stands low between frames
`timescale 1ns/1ps
`default_nettype none
module tssp_host (
  // from the device
  input wire logic sio_out,
  input wire logic sio_oe_out,
  // to the device
  output logic shift_clock_out,
  output logic cs_n_out,
  output wire logic sio_line_out
);
  logic host_oe = 1'b0;
  logic host_bit = 1'b0;
  logic float_bit = 1'b0;
  // released line shows a level that flips on every clock edge
  always @(shift_clock_out) float_bit = ~float_bit;
  assign sio_line_out = sio_oe_out ? sio_out : (host_oe ? host_bit : float_bit);
  initial begin
    shift_clock_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // one exchange: ntx bits read, then nrx command bits msb first
  task automatic xfer(input int ntx, input int nrx, input logic [15:0] cmd, input bit rel,
                      output logic [15:0] rd);
    rd = 16'h0000;
    if (cs_n_out) begin
      cs_n_out = 1'b0;
      #40;
    end
    for (int i = 0; i < ntx + nrx; i++) begin
      #10;
      if (i >= ntx) begin
        host_oe = 1'b1;
        host_bit = cmd[nrx - 1 - (i - ntx)];
      end
      #30;
      if (i < ntx) begin
        rd = {rd[14:0], sio_line_out};
      end
      shift_clock_out = 1'b1;
      #40;
      shift_clock_out = 1'b0;
    end
    #10;
    host_oe = 1'b0;
    if (rel) begin
      #30;
      cs_n_out = 1'b1;
      #200;
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_tssp_top.sv
// testbench for the serial port top with a host model on the link
// assumes CONV_CYCLES shortened to 50 system clocks
`timescale 1ns/1ps
`default_nettype none
module test_tssp_top;
  localparam logic [15:0] ID = 16'h3c28; // arbitrary value
  logic mclk_in = 1'b0;
  logic rst_n_in;
  logic [10:0] temp_code;
  logic [15:0] rd;
  wire logic sck, cs_n, line, sio_out, sio_oe, shutdown, valid, busy;
  int n_mismatch;
  int samples_checked;
  tssp_top #(.CONV_CYCLES(50), .DEVICE_ID(ID)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .shift_clock_in(sck), .cs_n_in(cs_n), .sio_in(line), .sio_out(sio_out), .sio_oe_out(sio_oe),
    .temp_code_in(temp_code), .shutdown_out(shutdown), .temp_valid_out(valid), .conv_busy_out(busy));
  tssp_host u_host (.sio_out(sio_out), .sio_oe_out(sio_oe), .shift_clock_out(sck), .cs_n_out(cs_n),
    .sio_line_out(line));
  // system clock
  always #5 mclk_in = ~mclk_in;
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // power-up state, then the first conversion
  task automatic t_reset();
    @(negedge mclk_in);
    @(negedge mclk_in);
    check({15'h0000, shutdown}, 16'h0000);
    check({15'h0000, busy}, 16'h0001);
    for (int i = 0; i < 500 && valid !== 1'b1; i++) @(negedge mclk_in);
    check({15'h0000, valid}, 16'h0001);
    if (valid !== 1'b1) give_verdict();
    $display("test reset done");
  endtask
  // temperature word after a new conversion; earlier command bits ignored
  task automatic t_read();
    @(negedge mclk_in);
    temp_code = 11'h59c;
    repeat (120) @(negedge mclk_in);
    u_host.xfer(16, 16, 16'hff00, 1'b1, rd);
    check({2'h0, rd[15:2]}, {2'h0, temp_code, 3'h7});
    check({15'h0000, shutdown}, 16'h0000);
    $display("test read done");
  endtask
  // each of eight codes with a zero leaves shutdown; id read while shut down
  task automatic t_codes();
    logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f};
    for (int k = 0; k < 8; k++) begin
      u_host.xfer(16, 16, 16'h00ff, 1'b1, rd);
      check({15'h0000, shutdown}, 16'h0001);
      u_host.xfer(16, 16, {8'hff, codes[k]}, 1'b1, rd);
      check({2'h0, rd[15:2]}, {2'h0, ID[15:2]});
      check({15'h0000, shutdown}, 16'h0000);
    end
    $display("test codes done");
  endtask
  // early release ends cleanly; a short command in shutdown changes nothing
  task automatic t_abort();
    u_host.xfer(6, 0, 16'h0000, 1'b1, rd);
    check({10'h000, rd[5:0]}, {10'h000, temp_code[10:5]});
    u_host.xfer(16, 16, 16'h00ff, 1'b1, rd);
    check({15'h0000, shutdown}, 16'h0001);
    u_host.xfer(16, 5, 16'h0000, 1'b1, rd);
    check({2'h0, rd[15:2]}, {2'h0, ID[15:2]});
    check({15'h0000, shutdown}, 16'h0001);
    u_host.xfer(16, 16, 16'h0000, 1'b1, rd);
    check({15'h0000, shutdown}, 16'h0000);
    $display("test abort done");
  endtask
  // power-up reset taken in shutdown restores conversion and clears valid
  task automatic t_power();
    u_host.xfer(16, 16, 16'h00ff, 1'b1, rd);
    check({15'h0000, shutdown}, 16'h0001);
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    @(negedge mclk_in);
    check({13'h0000, shutdown, valid, busy}, 16'h0001);
    for (int i = 0; i < 500 && valid !== 1'b1; i++) @(negedge mclk_in);
    check({15'h0000, valid}, 16'h0001);
    if (valid !== 1'b1) give_verdict();
    repeat (4) @(negedge mclk_in);
    u_host.xfer(16, 16, 16'h0000, 1'b1, rd);
    check({2'h0, rd[15:2]}, {2'h0, temp_code, 3'h7});
    $display("test power done");
  endtask
  // id readout and return to conversion in one long frame
  task automatic t_chain();
    u_host.xfer(16, 16, 16'h00ff, 1'b0, rd);
    u_host.xfer(16, 8, 16'h0000, 1'b1, rd);
    check({2'h0, rd[15:2]}, {2'h0, ID[15:2]});
    check({15'h0000, shutdown}, 16'h0000);
    $display("test chain done");
  endtask
  // reset for four clocks, then each scenario
  initial begin
    rst_n_in = 1'b0;
    temp_code = 11'h19a;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_read();
    t_codes();
    t_abort();
    t_chain();
    t_power();
    give_verdict();
  end
endmodule
`default_nettype wire
